// ==== hw/ssq_sequencer.sv ====
// Purpose: SDR SDRAM command sequencer with programmable timing
// Assumes: clk 100 MHz; memory bus clock is clk/2, commands change at its fall
// Notes: Close-page policy, every access ends with a precharge
// Functional notes
// - Column command follows activate by the programmed 1..16 bus clocks or more.
// - First read word is sampled after the programmed 1..16 bus clock latency.
// - Precharge delays are 1..16 clocks and refresh interval 128..16K clocks.
// - After the power-on precharge the row precharge time passes before the initial refresh.
// - After a mode register set, 2..17 idle clocks pass before any command.
// - After a refresh, the row cycle time passes before the next row strobe.
// - Leaving clock-off mode, the row cycle time passes before any access.
// - Every read and write is a burst of exactly four transfers.
// - Four memory clock outputs copy the forwarded memory clock.
// - Memory port has 64 data, 8 mask, 13 address, 2 bank, 4 select, 2 enable lines.
//
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
module ssq_sequencer #(
  parameter logic [14:0] REFRESH_RESET = 15'h4000
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic reqValid,
  output logic reqReady,
  input wire logic reqWrite,
  input wire logic [28:0] reqAddr,
  input wire logic [255:0] reqData,
  input wire logic [7:0] reqMask,
  output logic rdValid,
  input wire logic rdReady,
  output logic [255:0] rdData,
  output logic forwardedMemClock,
  output logic [3:0] memClkCopies,
  input wire logic feedbackMemClock,
  output logic [3:0] csN,
  output logic [1:0] cke,
  output logic [12:0] memAddr,
  output logic [1:0] bankSel,
  output logic rasN,
  output logic casN,
  output logic weN,
  output logic [7:0] byteMaskLines,
  input wire logic [63:0] dqIn,
  output logic [63:0] dqOut,
  output logic dqOeN
);
  import ssq_pkg::*;

  logic [31:0] ctrl_reg, timing_reg, status;
  logic [14:0] refresh_reg, refInterval, refCnt_reg;
  logic awHave_reg, wHave_reg, doWrite, mappedW, mappedR;
  logic [31:0] awAddr_reg, wData_reg;
  logic [3:0] wStrb_reg;
  ssq_state_e state_reg, ret_reg;
  ssq_cmd_e cmd_reg;
  logic [4:0] cnt_reg, latCnt_reg;
  logic [4:0] nRasCas, nCasRd, nRdPchg, nWrPchg, nRowPchg, nMrsIdle, nRowCyc;
  logic memClk_reg, tick, initDone_reg, refDue_reg, have_reg, hWrite_reg;
  logic [28:0] hAddr_reg;
  logic [255:0] hData_reg, line_reg, buf0_reg, buf1_reg;
  logic [7:0] hMask_reg, mask_reg;
  logic [1:0] beat_reg, capBeat_reg, bufCnt_reg;
  logic [3:0] cs_reg;
  logic [1:0] cke_reg, bank_reg;
  logic [12:0] mAddr_reg;
  logic [63:0] dqOut_reg, dq0_reg, dq1_reg;
  logic oeN_reg, capArm_reg, push_reg, reserve_reg, rdValid_reg, reqReady_reg;
  logic [2:0] fb_reg;
  logic fbRise, pop, room;
  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;

  // Byte-lane merge for AXI write strobes
  function automatic logic [31:0] merge(input logic [31:0] o, n, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[8*i +: 8] = n[8*i +: 8];
    end
    return r;
  endfunction : merge

  //////////////////////////////////////////////////////////////////////////////
  // Field decode to 1..16 and 2..17 counts
  assign nRasCas = 5'(timing_reg[TF_RAS_CAS +: 4]) + 5'd1;
  assign nCasRd = 5'(timing_reg[TF_CAS_RD +: 4]) + 5'd1;
  assign nRdPchg = 5'(timing_reg[TF_RD_PCHG +: 4]) + 5'd1;
  assign nWrPchg = 5'(timing_reg[TF_WR_PCHG +: 4]) + 5'd1;
  assign nRowPchg = 5'(timing_reg[TF_ROW_PCHG +: 4]) + 5'd1;
  assign nMrsIdle = 5'(timing_reg[TF_MRS_IDLE +: 4]) + 5'd2;
  assign nRowCyc = 5'(timing_reg[TF_ROW_CYC +: 4]) + 5'd2;
  // Out-of-range intervals are clamped rather than refused
  assign refInterval = (refresh_reg < REFRESH_MIN) ? REFRESH_MIN :
    (refresh_reg > REFRESH_MAX) ? REFRESH_MAX : refresh_reg;
  assign mappedW = awAddr_reg[31:4] == 28'h000_0000 && awAddr_reg[1:0] == 2'b00;
  assign mappedR = araddr[31:4] == 28'h000_0000 && araddr[1:0] == 2'b00;
  assign doWrite = awHave_reg && wHave_reg && !bvalid_reg;
  assign status = {26'h000_0000, bufCnt_reg, refDue_reg, (state_reg == S_CKOFF),
    (state_reg == S_IDLE), initDone_reg};

  //////////////////////////////////////////////////////////////////////////////
  // AXI write address and data, accepted in either order
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      awHave_reg <= 1'b0;
      awready_reg <= 1'b0;
      awAddr_reg <= 32'h0000_0000;
      wHave_reg <= 1'b0;
      wready_reg <= 1'b0;
      wData_reg <= 32'h0000_0000;
      wStrb_reg <= 4'h0;
    end else begin
      if (awvalid && awready_reg) begin
        awHave_reg <= 1'b1;
        awAddr_reg <= awaddr;
        awready_reg <= 1'b0;
      end else if (doWrite) begin
        awHave_reg <= 1'b0;
        awready_reg <= 1'b1;
      end else awready_reg <= !awHave_reg;
      if (wvalid && wready_reg) begin
        wHave_reg <= 1'b1;
        wData_reg <= wdata;
        wStrb_reg <= wstrb;
        wready_reg <= 1'b0;
      end else if (doWrite) begin
        wHave_reg <= 1'b0;
        wready_reg <= 1'b1;
      end else wready_reg <= !wHave_reg;
    end
  end

  // Register update and write response; status writes ignored
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl_reg <= CTRL_RESET;
      timing_reg <= TIMING_RESET;
      refresh_reg <= REFRESH_RESET;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (doWrite) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= mappedW ? RESP_OKAY : RESP_SLVERR;
      if (awAddr_reg == ADDR_CTRL) ctrl_reg <= merge(ctrl_reg, wData_reg, wStrb_reg);
      if (awAddr_reg == ADDR_TIMING) timing_reg <= merge(timing_reg, wData_reg, wStrb_reg);
      if (awAddr_reg == ADDR_REFRESH) refresh_reg <= 15'(merge({17'h0_0000, refresh_reg},
        wData_reg, wStrb_reg));
    end else if (bready) bvalid_reg <= 1'b0;
  end

  // AXI read channel, answered one cycle after the address
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
    end else if (arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rresp_reg <= mappedR ? RESP_OKAY : RESP_SLVERR;
      unique case (araddr)
        ADDR_CTRL: rdata_reg <= ctrl_reg;
        ADDR_TIMING: rdata_reg <= timing_reg;
        ADDR_REFRESH: rdata_reg <= {17'h0_0000, refresh_reg};
        ADDR_STATUS: rdata_reg <= status;
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end else if (rvalid_reg && rready) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end else arready_reg <= !rvalid_reg;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Memory clock divider; tick is the clk before each falling bus edge
  always_ff @(posedge clk) begin
    if (!reset_n) memClk_reg <= 1'b0;
    else memClk_reg <= !memClk_reg;
  end
  assign tick = memClk_reg;

  // Refresh interval counter; a new expiry wins over the clear
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      refCnt_reg <= 15'h0000;
      refDue_reg <= 1'b0;
    end else if (tick && initDone_reg && state_reg != S_CKOFF) begin
      if (refCnt_reg >= refInterval - 15'h0001) begin
        refCnt_reg <= 15'h0000;
        refDue_reg <= 1'b1;
      end else begin
        refCnt_reg <= refCnt_reg + 15'h0001;
        if (state_reg == S_REF) refDue_reg <= 1'b0;
      end
    end
  end

  // Request holding; reads need a free buffer slot
  assign room = !reserve_reg && bufCnt_reg != 2'h2;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      have_reg <= 1'b0;
      reqReady_reg <= 1'b0;
      hWrite_reg <= 1'b0;
      hAddr_reg <= 29'h0000_0000;
      hData_reg <= '0;
      hMask_reg <= 8'h00;
    end else if (reqValid && reqReady_reg) begin
      have_reg <= 1'b1;
      reqReady_reg <= 1'b0;
      hWrite_reg <= reqWrite;
      hAddr_reg <= reqAddr;
      hData_reg <= reqData;
      hMask_reg <= reqMask;
    end else begin
      if (tick && state_reg == S_ACT) have_reg <= 1'b0;
      reqReady_reg <= !have_reg && room && initDone_reg && state_reg == S_IDLE;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Command sequencer; spacing counted in bus clocks
  task automatic arm(input logic [4:0] n, input ssq_state_e r);
    state_reg <= (n <= 5'd1) ? r : S_WAIT;
    cnt_reg <= n;
    ret_reg <= r;
  endtask : arm

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= S_RESET;
      ret_reg <= S_IDLE;
      cnt_reg <= 5'd0;
      cmd_reg <= CMD_NOP;
      cs_reg <= 4'hF;
      cke_reg <= 2'b00;
      bank_reg <= 2'b00;
      mAddr_reg <= 13'h0000;
      beat_reg <= 2'h0;
      initDone_reg <= 1'b0;
    end else if (tick) begin
      cmd_reg <= CMD_NOP;
      cs_reg <= 4'hF;
      unique case (state_reg)
        S_RESET: if (ctrl_reg[CTRL_START]) begin
          cke_reg <= 2'b11;
          state_reg <= S_PALL;
        end
        S_PALL: begin
          cmd_reg <= CMD_PRE;
          cs_reg <= 4'h0;
          mAddr_reg <= ADDR_ALL_BANKS;
          arm(nRowPchg, S_IREF);
        end
        S_IREF: begin
          cmd_reg <= CMD_REF;
          cs_reg <= 4'h0;
          arm(nRowCyc, S_MRS);
        end
        S_MRS: begin
          cmd_reg <= CMD_MRS;
          cs_reg <= 4'h0;
          bank_reg <= 2'b00;
          mAddr_reg <= {6'h00, nCasRd[2:0], 1'b0, MODE_BURST4};
          arm(nMrsIdle, S_IDLE);
        end
        // Rows are always closed here, so a refresh may go at once
        S_IDLE: begin
          initDone_reg <= 1'b1;
          if (refDue_reg) state_reg <= S_REF;
          else if (ctrl_reg[CTRL_CKOFF]) begin
            cke_reg <= 2'b00;
            state_reg <= S_CKOFF;
          end else if (have_reg) state_reg <= S_ACT;
        end
        S_CKOFF: if (!ctrl_reg[CTRL_CKOFF]) begin
          cke_reg <= 2'b11;
          arm(nRowCyc, S_IDLE);
        end
        S_ACT: begin
          cmd_reg <= CMD_ACT;
          cs_reg <= ~(4'h1 << hAddr_reg[28:27]);
          bank_reg <= hAddr_reg[26:25];
          mAddr_reg <= hAddr_reg[22:10];
          arm(nRasCas, hWrite_reg ? S_WR : S_RD);
        end
        S_RD: begin
          cmd_reg <= CMD_RD;
          cs_reg <= ~(4'h1 << hAddr_reg[28:27]);
          mAddr_reg <= {3'h0, hAddr_reg[9:0]};
          arm(nRdPchg, S_PRE);
        end
        S_WR: begin
          cmd_reg <= CMD_WR;
          cs_reg <= ~(4'h1 << hAddr_reg[28:27]);
          mAddr_reg <= {3'h0, hAddr_reg[9:0]};
          beat_reg <= 2'h1;
          state_reg <= S_WBURST;
        end
        S_WBURST: begin
          beat_reg <= beat_reg + 2'h1;
          if (beat_reg == BURST_LAST) arm(nWrPchg, S_PRE);
        end
        S_PRE: begin
          cmd_reg <= CMD_PRE;
          cs_reg <= 4'h0;
          mAddr_reg <= ADDR_ALL_BANKS;
          arm(nRowPchg, S_IDLE);
        end
        S_REF: begin
          cmd_reg <= CMD_REF;
          cs_reg <= 4'h0;
          arm(nRowCyc, S_IDLE);
        end
        S_WAIT: begin
          cnt_reg <= cnt_reg - 5'd1;
          if (cnt_reg <= 5'd2) state_reg <= ret_reg;
        end
        default: state_reg <= S_RESET;
      endcase
    end
  end

  // Write data: four beats, then release
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      dqOut_reg <= '0;
      oeN_reg <= 1'b1;
      mask_reg <= 8'h00;
    end else if (tick) begin
      if (state_reg == S_WR || state_reg == S_WBURST) begin
        dqOut_reg <= hData_reg[64*beat_reg +: 64];
        oeN_reg <= 1'b0;
        mask_reg <= hMask_reg;
      end else begin
        oeN_reg <= 1'b1;
        mask_reg <= 8'h00;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Feedback clock and data synchronisers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      fb_reg <= 3'h0;
      dq0_reg <= '0;
      dq1_reg <= '0;
    end else begin
      fb_reg <= {fb_reg[1:0], feedbackMemClock};
      dq0_reg <= dqIn;
      dq1_reg <= dq0_reg;
    end
  end
  assign fbRise = fb_reg[1] && !fb_reg[2];

  // Read capture: latency, then four words on feedback edges
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      latCnt_reg <= 5'd0;
      capArm_reg <= 1'b0;
      capBeat_reg <= 2'h0;
      line_reg <= '0;
      push_reg <= 1'b0;
    end else begin
      push_reg <= 1'b0;
      if (tick && state_reg == S_RD) begin
        latCnt_reg <= nCasRd;
        capArm_reg <= 1'b1;
        capBeat_reg <= 2'h0;
      end else if (tick && latCnt_reg != 5'd0) latCnt_reg <= latCnt_reg - 5'd1;
      else if (capArm_reg && latCnt_reg == 5'd0 && fbRise) begin
        line_reg[64*capBeat_reg +: 64] <= dq1_reg;
        capBeat_reg <= capBeat_reg + 2'h1;
        if (capBeat_reg == BURST_LAST) begin
          capArm_reg <= 1'b0;
          push_reg <= 1'b1;
        end
      end
    end
  end

  // Two-entry read buffer; slot zero drives the output
  assign pop = rdValid_reg && rdReady;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      buf0_reg <= '0;
      buf1_reg <= '0;
      bufCnt_reg <= 2'h0;
      rdValid_reg <= 1'b0;
      reserve_reg <= 1'b0;
    end else begin
      if (reqValid && reqReady_reg && !reqWrite) reserve_reg <= 1'b1;
      else if (push_reg) reserve_reg <= 1'b0;
      if (push_reg && (bufCnt_reg == 2'h0 || (pop && bufCnt_reg == 2'h1))) buf0_reg <= line_reg;
      else if (pop) buf0_reg <= buf1_reg;
      if (push_reg && ((bufCnt_reg == 2'h1 && !pop) || bufCnt_reg == 2'h2)) buf1_reg <= line_reg;
      bufCnt_reg <= bufCnt_reg + {1'b0, push_reg} - {1'b0, pop};
      rdValid_reg <= (bufCnt_reg + {1'b0, push_reg} - {1'b0, pop}) != 2'h0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output drive, all from flip-flops
  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign reqReady = reqReady_reg;
  assign rdValid = rdValid_reg;
  assign rdData = buf0_reg;
  assign forwardedMemClock = memClk_reg;
  assign memClkCopies = {4{memClk_reg}};
  assign csN = cs_reg;
  assign cke = cke_reg;
  assign memAddr = mAddr_reg;
  assign bankSel = bank_reg;
  assign rasN = cmd_reg[2];
  assign casN = cmd_reg[1];
  assign weN = cmd_reg[0];
  assign byteMaskLines = mask_reg;
  assign dqOut = dqOut_reg;
  assign dqOeN = oeN_reg;
endmodule : ssq_sequencer

// ==== hw/ssq_pkg.sv ====
// Purpose: Sequencer constants
// Assumes: AXI4-Lite map, one word per register
// Notes: Timing fields hold count minus one (or minus two)
package ssq_pkg;
  // Register byte offsets
  localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
  localparam logic [31:0] ADDR_TIMING = 32'h0000_0004;
  localparam logic [31:0] ADDR_REFRESH = 32'h0000_0008;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_000C;
  // Control bits
  localparam int CTRL_START = 0;
  localparam int CTRL_CKOFF = 1;
  // Timing field positions, four bits each
  localparam int TF_RAS_CAS = 0;
  localparam int TF_CAS_RD = 4;
  localparam int TF_RD_PCHG = 8;
  localparam int TF_WR_PCHG = 12;
  localparam int TF_ROW_PCHG = 16;
  localparam int TF_MRS_IDLE = 20;
  localparam int TF_ROW_CYC = 24;
  // Reset values: slowest timing until software programs it
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] TIMING_RESET = 32'h0FFF_FFFF;
  localparam logic [14:0] REFRESH_MIN = 15'h0080;
  localparam logic [14:0] REFRESH_MAX = 15'h4000;
  localparam logic [1:0] BURST_LAST = 2'h3;
  localparam logic [12:0] ADDR_ALL_BANKS = 13'h0400;
  localparam logic [2:0] MODE_BURST4 = 3'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // SDRAM commands as {ras_n, cas_n, we_n}
  typedef enum logic [2:0] {
    CMD_MRS = 3'b000, CMD_REF = 3'b001, CMD_PRE = 3'b010, CMD_ACT = 3'b011,
    CMD_WR = 3'b100, CMD_RD = 3'b101, CMD_NOP = 3'b111
  } ssq_cmd_e;
  // Sequencer states
  typedef enum logic [3:0] {
    S_RESET = 4'h0, S_PALL = 4'h1, S_IREF = 4'h2, S_MRS = 4'h3, S_IDLE = 4'h4,
    S_ACT = 4'h5, S_RD = 4'h6, S_WR = 4'h7, S_WBURST = 4'h8, S_PRE = 4'h9,
    S_REF = 4'hA, S_CKOFF = 4'hB, S_WAIT = 4'hC
  } ssq_state_e;
endpackage : ssq_pkg

// ==== verif/ssq_mem_model.sv ====
// Purpose: Behavioural SDR SDRAM partner
// Assumes: Commands sampled on forwarded clock rises
// Notes: Released data lines show the inverted last word
`timescale 1ns/1ps
module ssq_mem_model
  import ssq_pkg::*;
(
  input wire logic forwardedMemClock,
  input wire logic feedbackMemClock,
  input wire logic [3:0] csN,
  input wire logic [12:0] memAddr,
  input wire logic [1:0] bankSel,
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  input wire logic [63:0] dqOut,
  input wire logic dqOeN,
  input wire logic [4:0] latTicks,
  output logic [63:0] dqIn
);
  logic [255:0] mem [logic [28:0]];
  logic [12:0] openRow [4];
  logic [28:0] wKey;
  logic [255:0] wBuf, rWord;
  logic [2:0] cmd;
  int wBeat = 4;
  realtime lastFb = 0;
  initial dqIn = 64'h0;
  assign cmd = (csN != 4'hF) ? {rasN, casN, weN} : CMD_NOP;
  ////////////////////////////////////////
  // Open rows per bank; write beats taken while driven
  always @(posedge forwardedMemClock) begin
    if (cmd == CMD_ACT) openRow[bankSel] = memAddr;
    if (cmd == CMD_WR) wKey = {csN, bankSel, openRow[bankSel], memAddr[9:0]};
    if (cmd == CMD_WR) wBeat = 0;
    if (wBeat < 4 && !dqOeN) begin
      wBuf[wBeat*64 +: 64] = dqOut;
      wBeat++;
      if (wBeat == 4) mem[wKey] = wBuf;
    end
  end
  // Read burst; a feedback rise under 30 ns old still reaches the block as beat one
  always @(posedge feedbackMemClock) lastFb = $realtime;
  always @(posedge forwardedMemClock) begin
    if (cmd == CMD_RD) begin
      rWord = mem[{csN, bankSel, openRow[bankSel], memAddr[9:0]}];
      dqIn = rWord[63:0];
      repeat (latTicks) @(posedge forwardedMemClock);
      for (int i = 1; i <= 4; i++) begin
        if (i > 1 || $realtime - lastFb >= 30) @(posedge feedbackMemClock);
        @(negedge feedbackMemClock);
        dqIn = (i < 4) ? rWord[i*64 +: 64] : ~dqIn;
      end
    end
  end
endmodule : ssq_mem_model

// ==== verif/ssq_seq_checker.sv ====
// Purpose: Command spacing and burst checks on the pins
// Assumes: Timing shadowed from completed writes
// Notes: Gaps counted in bus clocks, saturating at 63
`timescale 1ns/1ps
module ssq_seq_checker
  import ssq_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic forwardedMemClock,
  input wire logic [3:0] memClkCopies,
  input wire logic [3:0] csN,
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  input wire logic dqOeN
);
  logic fmcPrev, bPrev, lastWr, tick;
  logic [2:0] cmd;
  logic [31:0] awA, wD, tim;
  logic [5:0] sAct, sRef, sMrs, sPre, sWr, sRd;
  // Pins sampled one clk after the bus clock rises
  assign tick = forwardedMemClock && !fmcPrev;
  assign cmd = (csN != 4'hF) ? {rasN, casN, weN} : CMD_NOP;
  function automatic logic [5:0] step(input logic [5:0] c, input logic hit);
    return hit ? 6'h01 : (c == 6'h3F) ? c : c + 6'h01;
  endfunction : step
  ////////////////////////////////////////
  // Timing shadow taken when the write answers
  always_ff @(posedge clk) begin
    fmcPrev <= forwardedMemClock;
    bPrev <= bvalid;
    if (awvalid && awready) awA <= awaddr;
    if (wvalid && wready) wD <= wdata;
    if (!reset_n) tim <= TIMING_RESET;
    else if (bvalid && !bPrev && awA == ADDR_TIMING) tim <= wD;
  end
  // Saturated starts keep early commands legal
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      {sAct, sRef, sMrs, sPre, sWr, sRd} <= {6{6'h3F}};
      lastWr <= 1'b0;
    end else if (tick) begin
      sAct <= step(sAct, cmd == CMD_ACT);
      sRef <= step(sRef, cmd == CMD_REF);
      sMrs <= step(sMrs, cmd == CMD_MRS);
      sPre <= step(sPre, cmd == CMD_PRE);
      sWr <= step(sWr, cmd == CMD_WR);
      sRd <= step(sRd, cmd == CMD_RD);
      if (cmd == CMD_WR || cmd == CMD_RD) lastWr <= (cmd == CMD_WR);
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property gapAfter(logic hit, logic [5:0] since, logic [3:0] field, logic [5:0] extra);
    tick && hit |-> since >= {2'b00, field} + extra;
  endproperty
  copies_match_a: assert property (memClkCopies == {4{forwardedMemClock}})
    else $error("memory clock copies differ");
  act_col_gap_a: assert property (gapAfter(cmd == CMD_RD || cmd == CMD_WR, sAct,
    tim[TF_RAS_CAS +: 4], 6'h01)) else $error("column command too soon");
  mrs_idle_gap_a: assert property (tick && cmd != CMD_NOP |->
    sMrs >= {2'b00, tim[TF_MRS_IDLE +: 4]} + 6'h02) else $error("command too soon after mode set");
  ref_row_cycle_a: assert property (gapAfter(cmd == CMD_ACT, sRef,
    tim[TF_ROW_CYC +: 4], 6'h02)) else $error("activate too soon after refresh");
  row_pchg_gap_a: assert property (gapAfter(!cmd[2] && cmd != CMD_PRE, sPre,
    tim[TF_ROW_PCHG +: 4], 6'h01)) else $error("row strobe too soon after precharge");
  wr_pchg_gap_a: assert property (tick && cmd == CMD_PRE && lastWr |->
    sWr >= {2'b00, tim[TF_WR_PCHG +: 4]} + 6'h04) else $error("precharge too soon after write");
  rd_pchg_gap_a: assert property (gapAfter(cmd == CMD_PRE && !lastWr, sRd,
    tim[TF_RD_PCHG +: 4], 6'h01)) else $error("precharge too soon after read");
  write_burst_a: assert property (tick && cmd == CMD_WR |-> !dqOeN [*7] ##1 dqOeN)
    else $error("write burst is not four beats");
  refresh_seen_c: cover property (tick && cmd == CMD_REF);
  read_seen_c: cover property (tick && cmd == CMD_RD);
  mode_set_c: cover property (tick && cmd == CMD_MRS);
endmodule : ssq_seq_checker
bind ssq_sequencer ssq_seq_checker chk (.clk, .reset_n, .awaddr, .awvalid, .awready, .wdata,
  .wvalid, .wready, .bvalid, .forwardedMemClock, .memClkCopies, .csN, .rasN, .casN, .weN,
  .dqOeN);

// ==== verif/tb.sv ====
// Purpose: Self-checking bench for the sequencer
// Assumes: Free-running feedback clock, partner model on the pins
// Notes: Small timing fields keep command gaps short
`timescale 1ns/1ps
module tb;
  import ssq_pkg::*;
  logic clk = 0, reset_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, d, tim, seed = 32'h4a3a_76bd;
  logic awready, wready, bvalid, arready, rvalid, reqReady, rdValid, rasN, casN, weN, dqOeN;
  logic [3:0] wstrb = 4'hF, memClkCopies, csN;
  logic [1:0] bresp, rresp, r, cke, bankSel;
  logic reqValid = 0, reqWrite = 0, rdReady = 0, forwardedMemClock, feedbackMemClock = 0;
  logic [28:0] reqAddr = 0, a;
  logic [255:0] reqData = 0, rdData, v;
  logic [7:0] reqMask = 0, byteMaskLines;
  logic [12:0] memAddr;
  logic [63:0] dqIn, dqOut;
  logic [4:0] latTicks = 5'h01;
  logic [255:0] expMem [logic [28:0]];
  logic [28:0] addrs [$];
  logic [31:0] refVals [4] = '{32'h0000_7FFF, 32'h0000_4000, 32'h0000_0010, 32'h0000_0080};
  int n_errors = 0, comparisons = 0;
  always #5 clk = ~clk;
  // Feedback clock runs free
  always #40 feedbackMemClock = ~feedbackMemClock;
  ssq_sequencer DUT (.clk, .reset_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .reqValid, .reqReady, .reqWrite, .reqAddr, .reqData, .reqMask, .rdValid, .rdReady,
    .rdData, .forwardedMemClock, .memClkCopies, .feedbackMemClock, .csN, .cke, .memAddr,
    .bankSel, .rasN, .casN, .weN, .byteMaskLines, .dqIn, .dqOut, .dqOeN);
  ssq_mem_model memModel (.forwardedMemClock, .feedbackMemClock, .csN, .memAddr, .bankSel,
    .rasN, .casN, .weN, .dqOut, .dqOeN, .latTicks, .dqIn);
  ////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Refresh readback gives the stored bits
  function automatic logic [31:0] refreshExp(input logic [31:0] x);
    return x & 32'h0000_7FFF;
  endfunction : refreshExp
  task automatic print_verdict;
    if (n_errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  task automatic fail(input string m);
    n_errors++;
    $display("[FAIL] %0t %s", $time, m);
  endtask : fail
  task automatic hang;
    fail("timeout");
    print_verdict();
  endtask : hang
  task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) fail($sformatf("register %h expected %h", got, exp));
  endtask : chkReg
  task automatic chkBurst(input logic [255:0] got, input logic [255:0] exp);
    comparisons++;
    if (got !== exp) fail($sformatf("burst %h expected %h", got, exp));
  endtask : chkBurst
  // Register write; aw and w offered together
  task automatic axiWr(input logic [31:0] ad, input logic [31:0] x);
    int n = 0;
    @(posedge clk);
    awaddr <= ad;
    wdata <= x;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge clk);
      awvalid <= awvalid && !awready;
      wvalid <= wvalid && !wready;
      n++;
    end while (!bvalid && n < 64);
    r = bresp;
    bready <= 0;
    if (n >= 64) hang();
  endtask : axiWr
  task automatic axiRd(input logic [31:0] ad);
    int n = 0;
    @(posedge clk);
    araddr <= ad;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge clk);
      arvalid <= arvalid && !arready;
      n++;
    end while (!rvalid && n < 64);
    d = rdata;
    r = rresp;
    rready <= 0;
    if (n >= 64) hang();
  endtask : axiRd
  task automatic poll(input int b, input logic x);
    int n;
    for (n = 0; n < 200; n++) begin
      axiRd(ADDR_STATUS);
      if (d[b] === x) break;
    end
    if (n == 200) hang();
  endtask : poll
  // Request port; reads stall the receiver at random
  task automatic memReq(input logic [28:0] ad, input logic wr, input logic [255:0] x);
    int n = 0;
    @(posedge clk);
    reqValid <= 1;
    reqWrite <= wr;
    reqAddr <= ad;
    reqData <= x;
    do begin
      @(posedge clk);
      n++;
    end while (!reqReady && n < 3000);
    reqValid <= 0;
    if (!wr) begin
      seed = lfsr(seed);
      repeat (seed[2:0]) @(posedge clk);
      rdReady <= 1;
      do begin
        @(posedge clk);
        n++;
      end while (!rdValid && n < 3000);
      rdReady <= 0;
      chkBurst(rdData, expMem[ad]);
    end
    if (n >= 3000) hang();
  endtask : memReq
  ////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1;
    repeat (2) @(posedge clk);
    axiRd(ADDR_TIMING);
    chkReg(d, TIMING_RESET);
    axiRd(32'h0000_0010);
    chkReg({30'h0, r}, {30'h0, RESP_SLVERR});
    foreach (refVals[i]) begin
      axiWr(ADDR_REFRESH, refVals[i]);
      axiRd(ADDR_REFRESH);
      chkReg(d, refreshExp(refVals[i]));
    end
    seed = lfsr(seed);
    tim = seed & 32'h0333_3330;
    latTicks <= {1'b0, tim[TF_CAS_RD +: 4]} + 5'h01;
    axiWr(ADDR_TIMING, tim);
    chkReg({30'h0, r}, {30'h0, RESP_OKAY});
    axiWr(ADDR_CTRL, 32'h0000_0001);
    poll(0, 1'b1);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      a = (i == 0) ? 29'h0 : (i == 1) ? 29'h1E7F_FFFC : seed[28:0] & 29'h1E7F_FFFC;
      for (int k = 0; k < 8; k++) begin
        seed = lfsr(seed);
        v[k*32 +: 32] = seed;
      end
      expMem[a] = v;
      addrs.push_back(a);
      memReq(a, 1'b1, v);
    end
    foreach (addrs[k]) memReq(addrs[k], 1'b0, 256'h0);
    axiWr(ADDR_CTRL, 32'h0000_0002);
    poll(2, 1'b1);
    axiWr(ADDR_CTRL, 32'h0000_0000);
    poll(2, 1'b0);
    foreach (addrs[k]) memReq(addrs[k], 1'b0, 256'h0);
    print_verdict();
  end
endmodule : tb
